//--- isfe_addr_match.v
// isfe_addr_match.v: four instruction-address compare channels
`timescale 1ns/1ns
`include "isfe_map.vh"

module isfe_addr_match (
	input  wire                  clk_sys,
	input  wire                  arst_n,
	input  wire [4*`ISFE_AW-1:0] cmp_addr,
	input  wire [3:0]            cmp_enable,
	input  wire [`ISFE_AW-1:0]   fetch_addr,
	input  wire                  fetch_start,
	input  wire                  fetch_long,
	input  wire                  fetch_external,
	input  wire                  bus_8bit,
	output reg                   am_request,
	output reg  [1:0]            am_channel,
	output reg  [`ISFE_AW-1:0]   am_saved_pc
);

	wire [3:0] hit;
	reg  [1:0] next_chan;
	integer    k;
	genvar     c;

	// ****************************************
	// compare per channel
	// ****************************************
	generate
		for (c = 0; c < 4; c = c + 1) begin : g_ch
			// external fetches excluded on an 8-bit bus
			assign hit[c] = cmp_enable[c] & fetch_start &
				~(fetch_external & bus_8bit) &
				(fetch_addr == cmp_addr[c*`ISFE_AW +: `ISFE_AW]);
		end
	endgenerate

	// lowest channel wins when two compare equal
	always @* begin
		next_chan = 2'h0;
		for (k = 3; k >= 0; k = k - 1) begin
			if (hit[k]) begin
				next_chan = k[1:0];
			end
		end
	end

	// request pulse and saved counter, ignoring mask and level
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			am_request  <= 1'b0;
			am_channel  <= 2'h0;
			am_saved_pc <= {`ISFE_AW{1'b0}};
		end else begin
			am_request <= |hit;
			if (|hit) begin
				am_channel <= next_chan;
				if (fetch_long) begin
					am_saved_pc <= fetch_addr + 20'h00002;
				end else begin
					am_saved_pc <= fetch_addr + 20'h00001;
				end
			end
		end
	end

endmodule // isfe_addr_match

//--- isfe_front_end.v
// isfe_front_end.v: interrupt source front end with AXI4-Lite registers
//
// Function
// - six external request pins raise requests on edges chosen by select 1
// - select 1 bit per pin: 0 one edge, 1 both edges
// - ext4 shares slot with serial3/CAN1 transmit; select bit 1 picks ext4
// - ext5 shares slot with CAN1 receive; select bit 1 picks ext5
// - select 0 bit 0: 0 CAN1 transmit, 1 serial channel 3
// - select 0 bit 1: 0 analog conversion, 1 key input
// - select 0 bit 2 routes CAN wake/error onto vectors 7 and 8
// - select 0 bit 6: 0 timer B3, 1 UART0 bus collision
// - select 0 bit 7: 0 timer B4, 1 UART1 bus collision
// - non-maskable pin falling raises an ungated non-maskable request
// - non-maskable pin level readable; pin is no general input
// - key request when any input-direction key pin goes low
// - key request wakes the device from wait or stop
// - while one key pin is low, other falling key pins are ignored
// - falling edge on either CAN receive pin raises wake-up, shared on vector 7 while select 0 bit 2 is 0
// - CAN wake-up only with pin function enable and sleep both 1
// - four compare channels request before the matching instruction runs
// - saved counter is compare address plus 2 or plus 1
// - no address match on external areas with an 8-bit bus
// - accept maskable request only with enable, flag, level above PROCESSOR_PRIORITY_LEVEL
`timescale 1ns/1ns
`include "isfe_map.vh"

module isfe_front_end (
	input  wire                    clk_sys,
	input  wire                    arst_n,
	input  wire [7:0]              s_axi_awaddr,
	input  wire                    s_axi_awvalid,
	output reg                     s_axi_awready,
	input  wire [31:0]             s_axi_wdata,
	input  wire [3:0]              s_axi_wstrb,
	input  wire                    s_axi_wvalid,
	output reg                     s_axi_wready,
	output reg  [1:0]              s_axi_bresp,
	output reg                     s_axi_bvalid,
	input  wire                    s_axi_bready,
	input  wire [7:0]              s_axi_araddr,
	input  wire                    s_axi_arvalid,
	output reg                     s_axi_arready,
	output reg  [31:0]             s_axi_rdata,
	output reg  [1:0]              s_axi_rresp,
	output reg                     s_axi_rvalid,
	input  wire                    s_axi_rready,
	input  wire [5:0]              ext_request_input,
	input  wire [5:0]              edge_polarity_bit,
	input  wire                    nonmaskable_pin_n,
	input  wire [3:0]              key_pin,
	input  wire                    can0_receive_pin,
	input  wire                    can1_receive_pin,
	input  wire [1:0]              can_pin_function_enable,
	input  wire [1:0]              can_sleep,
	input  wire                    can0_error,
	input  wire                    can1_error,
	input  wire                    can1_tx_done,
	input  wire                    can1_rx_done,
	input  wire                    serial3_done,
	input  wire                    adc_done,
	input  wire                    timer_b3_done,
	input  wire                    timer_b4_done,
	input  wire                    uart0_collision,
	input  wire                    uart1_collision,
	input  wire                    cpu_global_enable,
	input  wire [2:0]              processor_priority_level,
	input  wire [3*`ISFE_NVEC-1:0] source_level,
	input  wire [`ISFE_NVEC-1:0]   cpu_accept,
	input  wire [`ISFE_AW-1:0]     fetch_addr,
	input  wire                    fetch_start,
	input  wire                    fetch_long,
	input  wire                    fetch_external,
	input  wire                    bus_8bit,
	output reg  [`ISFE_NVEC-1:0]   request_flag,
	output reg                     maskable_accept,
	output reg                     nmi_request,
	output reg                     key_wakeup,
	output wire                    am_request,
	output wire [1:0]              am_channel,
	output wire [`ISFE_AW-1:0]     am_saved_pc
);

	// ****************************************
	// registers and internal signals
	// ****************************************
	reg  [7:0]               sel0;
	reg  [7:0]               sel1;
	reg  [3:0]               am_enable;
	reg  [3:0]               port10_direction_reg;
	reg  [4*`ISFE_AW-1:0]    address_compare_reg;
	reg                      aw_held;
	reg  [7:0]               aw_addr_q;
	reg                      w_held;
	reg  [31:0]              w_data_q;
	reg  [3:0]               w_strb_q;
	reg                      key_active_q;
	reg  [`ISFE_NVEC-1:0]    next_flag;
	reg  [`ISFE_NVEC-1:0]    set_vec;
	reg  [31:0]              rd_word;
	reg                      rd_ok;
	reg                      wr_ok;
	wire                     wr_go;
	wire [31:0]              wr_mask;
	wire [31:0]              wr_set;
	wire [31:0]              wr_bits;
	wire [`ISFE_NVEC-1:0]    flag_clr;
	wire [`ISFE_NVEC-1:0]    lvl_ok;
	wire [5:0]               ext_fall;
	wire [5:0]               ext_rise;
	wire [5:0]               ext_hit;
	wire [3:0]               key_lvl;
	wire [1:0]               key_lvl_can_unused;
	wire [3:0]               key_fall_unused;
	wire [1:0]               can_fall;
	wire [1:0]               can_wake;
	wire                     nmi_lvl;
	wire                     nmi_fall;
	wire                     key_active;
	integer                  j;
	genvar                   i;

	// ****************************************
	// pin synchronisers
	// ****************************************
	// all pins share one synchroniser module, one instance per group
	isfe_sync_edge #(.W(6)) u_ext (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.pin_in  (ext_request_input),
		.level   (),
		.fall    (ext_fall),
		.rise    (ext_rise)
	);

	isfe_sync_edge #(.W(7)) u_misc (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.pin_in  ({nonmaskable_pin_n, can1_receive_pin,
			can0_receive_pin, key_pin}),
		.level   ({nmi_lvl, key_lvl_can_unused, key_lvl}),
		.fall    ({nmi_fall, can_fall, key_fall_unused}),
		.rise    ()
	);

	// ****************************************
	// edge selection and source routing
	// ****************************************
	generate
		for (i = 0; i < `ISFE_NEXT; i = i + 1) begin : g_ext
			// pin polarity only matters in one-edge mode
			assign ext_hit[i] = sel1[i] ? (ext_rise[i] | ext_fall[i]) :
				(edge_polarity_bit[i] ? ext_rise[i] : ext_fall[i]);
		end
	endgenerate

	// input-direction pins only; a held-low pin masks the rest
	assign key_active = |(~key_lvl & ~port10_direction_reg);
	assign can_wake = can_fall & can_pin_function_enable & can_sleep;

	// per-vector set terms after the shared-slot multiplexers
	always @* begin
		set_vec[3:0] = ext_hit[3:0];
		if (sel1[`ISFE_S1_EXT4_SEL]) begin
			set_vec[4] = ext_hit[4];
		end else if (sel0[`ISFE_S0_TX_SER3]) begin
			set_vec[4] = serial3_done;
		end else begin
			set_vec[4] = can1_tx_done;
		end
		set_vec[5] = sel1[`ISFE_S1_EXT5_SEL] ? ext_hit[5] :
			can1_rx_done;
		// only the low-going change of the combined level counts
		set_vec[6] = sel0[`ISFE_S0_ADC_KEY] ?
			(key_active & ~key_active_q) : adc_done;
		if (sel0[`ISFE_S0_CAN_WE]) begin
			set_vec[7] = can_wake[0] | can0_error;
			set_vec[8] = can_wake[1] | can1_error;
		end else begin
			set_vec[7] = |can_wake;
			set_vec[8] = can0_error | can1_error;
		end
		set_vec[9] = sel0[`ISFE_S0_TB3_COL0] ? uart0_collision :
			timer_b3_done;
		set_vec[10] = sel0[`ISFE_S0_TB4_COL1] ? uart1_collision :
			timer_b4_done;
	end

	// ****************************************
	// request flags and acceptance
	// ****************************************
	assign wr_go    = aw_held & w_held & ~s_axi_bvalid;
	assign wr_mask  = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wr_set   = w_data_q & wr_mask;
	assign wr_bits  = wr_set | ~wr_mask;
	// writing 0 clears, writing 1 leaves the flag alone
	assign flag_clr = (wr_go && aw_addr_q == `ISFE_OFF_FLAGS) ?
		~wr_bits[`ISFE_NVEC-1:0] : {`ISFE_NVEC{1'b0}};

	// a set in the clearing cycle wins over the clear
	always @* begin
		next_flag = (request_flag & ~(flag_clr | cpu_accept)) | set_vec;
	end

	generate
		for (i = 0; i < `ISFE_NVEC; i = i + 1) begin : g_acc
			assign lvl_ok[i] = request_flag[i] &
				(source_level[3*i +: 3] > processor_priority_level);
		end
	endgenerate

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			request_flag    <= {`ISFE_NVEC{1'b0}};
			maskable_accept <= 1'b0;
			nmi_request     <= 1'b0;
			key_wakeup      <= 1'b0;
			key_active_q    <= 1'b0;
		end else begin
			request_flag    <= next_flag;
			maskable_accept <= cpu_global_enable & (|lvl_ok);
			nmi_request     <= nmi_fall;
			key_wakeup      <= key_active;
			key_active_q    <= key_active;
		end
	end

	// ****************************************
	// address match channels
	// ****************************************
	isfe_addr_match u_am (
		.clk_sys        (clk_sys),
		.arst_n         (arst_n),
		.cmp_addr       (address_compare_reg),
		.cmp_enable     (am_enable),
		.fetch_addr     (fetch_addr),
		.fetch_start    (fetch_start),
		.fetch_long     (fetch_long),
		.fetch_external (fetch_external),
		.bus_8bit       (bus_8bit),
		.am_request     (am_request),
		.am_channel     (am_channel),
		.am_saved_pc    (am_saved_pc)
	);

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	always @* begin
		case (aw_addr_q)
			`ISFE_OFF_SEL0, `ISFE_OFF_SEL1, `ISFE_OFF_AM_EN,
			`ISFE_OFF_DIR10, `ISFE_OFF_FLAGS, `ISFE_OFF_PINS,
			`ISFE_OFF_CMP0, `ISFE_OFF_CMP1, `ISFE_OFF_CMP2,
			`ISFE_OFF_CMP3: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// address and data are taken in either order, answered after both
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ISFE_RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held       <= 1'b1;
				aw_addr_q     <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held       <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `ISFE_RESP_OKAY : `ISFE_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// register updates; unassigned select 0 bits are not stored
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sel0                 <= `ISFE_RST_SEL0;
			sel1                 <= `ISFE_RST_SEL1;
			am_enable            <= 4'h0;
			port10_direction_reg <= `ISFE_RST_DIR10;
			address_compare_reg  <= {4*`ISFE_AW{1'b0}};
		end else if (wr_go) begin
			case (aw_addr_q)
				`ISFE_OFF_SEL0: sel0 <= `ISFE_S0_MASK &
					((sel0 & ~wr_mask[7:0]) | wr_set[7:0]);
				`ISFE_OFF_SEL1: sel1 <= (sel1 & ~wr_mask[7:0]) |
					wr_set[7:0];
				`ISFE_OFF_AM_EN: am_enable <=
					(am_enable & ~wr_mask[3:0]) | wr_set[3:0];
				`ISFE_OFF_DIR10: port10_direction_reg <=
					(port10_direction_reg & ~wr_mask[3:0]) | wr_set[3:0];
				default: begin
					for (j = 0; j < 4; j = j + 1) begin
						if (aw_addr_q == `ISFE_OFF_CMP0 + 4*j) begin
							address_compare_reg[j*`ISFE_AW +: `ISFE_AW] <=
								(address_compare_reg[j*`ISFE_AW +: `ISFE_AW] &
								~wr_mask[19:0]) | wr_set[19:0];
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	always @* begin
		rd_ok   = 1'b1;
		rd_word = 32'h00000000;
		case ({s_axi_araddr[7:2], 2'b00})
			`ISFE_OFF_SEL0:  rd_word[7:0] = sel0;
			`ISFE_OFF_SEL1:  rd_word[7:0] = sel1;
			`ISFE_OFF_AM_EN: rd_word[3:0] = am_enable;
			`ISFE_OFF_DIR10: rd_word[3:0] = port10_direction_reg;
			`ISFE_OFF_FLAGS: rd_word[`ISFE_NVEC-1:0] = request_flag;
			// non-maskable pin level is visible here only
			`ISFE_OFF_PINS:  rd_word[8:0] = {key_active, key_lvl,
				3'h0, nmi_lvl};
			`ISFE_OFF_CMP0:  rd_word[19:0] = address_compare_reg[19:0];
			`ISFE_OFF_CMP1:  rd_word[19:0] = address_compare_reg[39:20];
			`ISFE_OFF_CMP2:  rd_word[19:0] = address_compare_reg[59:40];
			`ISFE_OFF_CMP3:  rd_word[19:0] = address_compare_reg[79:60];
			default:         rd_ok = 1'b0;
		endcase
	end

	// one read at a time; data captured when the address is taken
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `ISFE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_ok ? `ISFE_RESP_OKAY : `ISFE_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // isfe_front_end

//--- isfe_front_end_assertions.sv
// isfe_front_end_assertions.sv: port checker for the source front end
`timescale 1ns/1ns
`include "isfe_map.vh"

module isfe_fe_chk (
	input logic                  clk_sys,
	input logic                  arst_n,
	input logic                  s_axi_awready,
	input logic                  s_axi_wready,
	input logic                  s_axi_bvalid,
	input logic [5:0]            ext_request_input,
	input logic [5:0]            edge_polarity_bit,
	input logic                  nonmaskable_pin_n,
	input logic [3:0]            key_pin,
	input logic                  cpu_global_enable,
	input logic [`ISFE_AW-1:0]   fetch_addr,
	input logic                  fetch_start,
	input logic                  fetch_long,
	input logic [`ISFE_NVEC-1:0] request_flag,
	input logic                  maskable_accept,
	input logic                  nmi_request,
	input logic                  key_wakeup,
	input logic                  am_request,
	input logic [`ISFE_AW-1:0]   am_saved_pc
);
	// ****************************************
	// pin paths: two sync stages plus edge stage
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	chk_nmi_fall: assert property (
		$fell(nonmaskable_pin_n) |-> ##3 nmi_request)
		else $error("nmi request missing");
	chk_nmi_single: assert property (
		nmi_request |=> !nmi_request)
		else $error("nmi pulse too long");
	chk_nmi_cause: assert property (
		nmi_request |-> !$past(nonmaskable_pin_n, 3) &&
		$past(nonmaskable_pin_n, 4))
		else $error("nmi without pin fall");
	chk_ext_fall: assert property (
		$fell(ext_request_input[0]) && !edge_polarity_bit[0]
		|-> ##3 request_flag[0])
		else $error("ext0 falling edge lost");
	chk_key_wake: assert property (
		key_wakeup |-> $past(key_pin, 3) != 4'hF)
		else $error("wakeup without low key");

	// ****************************************
	// compare channels, acceptance, bus
	// ****************************************
	chk_am_cause: assert property (
		am_request |-> $past(fetch_start))
		else $error("match request without fetch");
	chk_am_pc: assert property (
		am_request |-> am_saved_pc == $past(fetch_addr)
		+ ($past(fetch_long) ? 20'h00002 : 20'h00001))
		else $error("saved counter wrong");
	chk_accept_gate: assert property (
		maskable_accept |-> $past(cpu_global_enable) && $past(|request_flag))
		else $error("accept without enable or flag");
	chk_b_busy: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready during response");

	cover property (am_request);
	cover property (nmi_request);
	cover property (maskable_accept);
	cover property (key_wakeup);
endmodule // isfe_fe_chk

bind isfe_front_end isfe_fe_chk u_chk (.*);

//--- isfe_front_end_tb.sv
// isfe_front_end_tb.sv: self-checking bench for the source front end
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (e)); end end

module isfe_front_end_tb;
	logic        clk_sys = 1'h0, arst_n = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	logic [12:0] pins = 13'h1FFF;
	wire  [5:0]  ext_request_input = pins[5:0];
	wire         nonmaskable_pin_n = pins[6];
	wire  [3:0]  key_pin = pins[10:7];
	wire         can0_receive_pin = pins[11], can1_receive_pin = pins[12];
	logic [5:0]  edge_polarity_bit = 6'h00;
	logic [1:0]  can_pin_function_enable = 2'h3, can_sleep = 2'h3;
	logic [9:0]  per = 10'h000;
	wire         can0_error = per[0], can1_error = per[1], can1_tx_done = per[2],
		can1_rx_done = per[3], serial3_done = per[4], adc_done = per[5],
		timer_b3_done = per[6], timer_b4_done = per[7],
		uart0_collision = per[8], uart1_collision = per[9];
	logic        cpu_global_enable = 1'h0, ack_en = 1'h0;
	logic [2:0]  processor_priority_level = 3'h3;
	logic [32:0] source_level = {11{3'h4}};
	wire  [10:0] cpu_accept, request_flag;
	logic [19:0] fetch_addr = 20'h00000;
	logic        fetch_start = 1'h0, fetch_long = 1'h0;
	logic        fetch_external = 1'h0, bus_8bit = 1'h0;
	wire         maskable_accept, nmi_request, key_wakeup, am_request;
	wire  [1:0]  am_channel;
	wire  [19:0] am_saved_pc;
	logic [1:0]  rs;
	logic [31:0] d;
	int          miscompares = 0, num_checks = 0, nmis = 0;

	isfe_front_end dut (.*);
	isfe_partner u_cpu (.*);

	// ****************************************
	// clock, pulse counter, bus tasks
	// ****************************************
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (nmi_request === 1'h1) nmis <= nmis + 1;

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// valids drop when taken; bready up until the response
	task automatic axw(input [7:0] a, input [31:0] v);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic axr(input [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rdc(input [7:0] a, input [31:0] e);
		axr(a);
		`CHK({rs, d}, {2'h0, e})
	endtask
	// pin change, check flags, clear all
	task automatic pe(input int b, input bit v, input [10:0] e);
		@(posedge clk_sys);
		pins[b] <= v;
		wt(6);
		`CHK(request_flag, e)
		axw(8'h10, 32'h0);
	endtask
	task automatic pp(input int s, input int f);
		@(posedge clk_sys);
		per[s] <= 1'h1;
		@(posedge clk_sys);
		per[s] <= 1'h0;
		wt(2);
		`CHK(request_flag, (f > 10) ? 11'h000 : 11'h001 << f)
		axw(8'h10, 32'h0);
	endtask
	task automatic fe(input [19:0] a, input l, x, b, q, input [1:0] c,
		input [19:0] p);
		@(posedge clk_sys);
		fetch_addr <= a;
		fetch_long <= l;
		fetch_external <= x;
		bus_8bit <= b;
		fetch_start <= 1'h1;
		@(posedge clk_sys);
		fetch_start <= 1'h0;
		@(posedge clk_sys);
		`CHK(am_request, q)
		if (q) `CHK({am_channel, am_saved_pc}, {c, p})
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reg;
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'h0);
		axw(8'h00, 32'hFF);
		rdc(8'h00, 32'hC7);
		axw(8'h04, 32'hA5);
		rdc(8'h04, 32'hA5);
		axr(8'h30);
		`CHK({rs, d}, {2'h2, 32'h0})
		axw(8'h30, 32'h1);
		`CHK(rs, 2'h2)
		axw(8'h00, 32'h0);
		axw(8'h04, 32'h0);
		$display("register test done");
	endtask
	task automatic t_ext;
		for (int i = 0; i < 6; i++) begin
			axw(8'h04, 32'hC0);
			axw(8'h10, 32'h0);
			pe(i, 0, 11'h001 << i);
			pe(i, 1, 11'h000);
			edge_polarity_bit[i] <= 1'h1;
			pe(i, 0, 11'h000);
			pe(i, 1, 11'h001 << i);
			edge_polarity_bit[i] <= 1'h0;
			axw(8'h04, 32'hC0 | (32'h1 << i));
			axw(8'h10, 32'h0);
			pe(i, 0, 11'h001 << i);
			pe(i, 1, 11'h001 << i);
		end
		$display("edge test done");
	endtask
	task automatic t_route;
		int fb0[10] = '{8, 8, 4, 5, 15, 6, 9, 10, 15, 15};
		int fb1[10] = '{7, 8, 15, 5, 4, 15, 15, 15, 9, 10};
		axw(8'h04, 32'h0);
		for (int k = 0; k < 2; k++) begin
			axw(8'h00, k ? 32'hC7 : 32'h0);
			for (int s = 0; s < 10; s++)
				pp(s, k ? fb1[s] : fb0[s]);
		end
		axw(8'h04, 32'hC0);
		pp(4, 15);
		pp(3, 15);
		axw(8'h04, 32'h0);
		axw(8'h00, 32'h0);
		$display("routing test done");
	endtask
	task automatic t_key;
		axw(8'h00, 32'h2);
		pe(7, 0, 11'h040);
		`CHK(key_wakeup, 1'h1)
		pe(8, 0, 11'h000);
		pe(7, 1, 11'h000);
		pe(8, 1, 11'h000);
		axw(8'h0C, 32'h1);
		pe(7, 0, 11'h000);
		`CHK(key_wakeup, 1'h0)
		pe(7, 1, 11'h000);
		axw(8'h0C, 32'h0);
		$display("key test done");
	endtask
	task automatic t_can;
		axw(8'h00, 32'h0);
		pe(11, 0, 11'h080);
		pe(11, 1, 11'h000);
		pe(12, 0, 11'h080);
		pe(12, 1, 11'h000);
		can_sleep <= 2'h2;
		pe(11, 0, 11'h000);
		pe(11, 1, 11'h000);
		can_sleep <= 2'h3;
		can_pin_function_enable <= 2'h2;
		pe(11, 0, 11'h000);
		pe(11, 1, 11'h000);
		can_pin_function_enable <= 2'h3;
		axw(8'h00, 32'h4);
		pe(12, 0, 11'h100);
		pe(12, 1, 11'h000);
		pe(11, 0, 11'h080);
		pe(11, 1, 11'h000);
		axw(8'h00, 32'h0);
		$display("wake test done");
	endtask
	task automatic t_nmi;
		rdc(8'h14, 32'hF1);
		pe(6, 0, 11'h000);
		`CHK(nmis, 1)
		rdc(8'h14, 32'hF0);
		pe(6, 1, 11'h000);
		`CHK(nmis, 1)
		$display("nmi test done");
	endtask
	task automatic t_am;
		axw(8'h20, 32'h12344);
		axw(8'h2C, 32'h0ABCD);
		axw(8'h08, 32'h9);
		fe(20'h12344, 1, 0, 0, 1, 0, 20'h12346);
		fe(20'h0ABCD, 0, 0, 0, 1, 3, 20'h0ABCE);
		fe(20'h12344, 1, 1, 1, 0, 0, 20'h00000);
		fe(20'h12344, 0, 1, 0, 1, 0, 20'h12345);
		fe(20'h12340, 0, 0, 0, 0, 0, 20'h00000);
		axw(8'h08, 32'h8);
		fe(20'h12344, 0, 0, 0, 0, 0, 20'h00000);
		$display("match test done");
	endtask
	task automatic t_acc;
		@(posedge clk_sys);
		per[5] <= 1'h1;
		@(posedge clk_sys);
		per[5] <= 1'h0;
		wt(3);
		`CHK(maskable_accept, 1'h0)
		cpu_global_enable <= 1'h1;
		wt(3);
		`CHK(maskable_accept, 1'h1)
		processor_priority_level <= 3'h4;
		wt(3);
		`CHK(maskable_accept, 1'h0)
		processor_priority_level <= 3'h3;
		ack_en <= 1'h1;
		wt(6);
		`CHK({request_flag, maskable_accept}, 12'h000)
		ack_en <= 1'h0;
		$display("accept test done");
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// watchdog: tests need under 10000 cycles
	initial begin
		wt(30000);
		miscompares++;
		give_verdict;
	end
	initial begin
		wt(10);
		arst_n <= 1'h1;
		t_reg;
		t_ext;
		t_route;
		t_key;
		t_can;
		t_nmi;
		t_am;
		t_acc;
		give_verdict;
	end
endmodule // isfe_front_end_tb

//--- isfe_map.vh
// isfe_map.vh: offsets, fields, reset values for the source front end
`ifndef ISFE_MAP_VH
`define ISFE_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define ISFE_OFF_SEL0      8'h00
`define ISFE_OFF_SEL1      8'h04
`define ISFE_OFF_AM_EN     8'h08
`define ISFE_OFF_DIR10     8'h0C
`define ISFE_OFF_FLAGS     8'h10
`define ISFE_OFF_PINS      8'h14
`define ISFE_OFF_CMP0      8'h20
`define ISFE_OFF_CMP1      8'h24
`define ISFE_OFF_CMP2      8'h28
`define ISFE_OFF_CMP3      8'h2C

// ****************************************
// reset values
// ****************************************
`define ISFE_RST_SEL0      8'h00
`define ISFE_RST_SEL1      8'h00
`define ISFE_RST_DIR10     4'h0

// ****************************************
// field positions, select register 0
// ****************************************
`define ISFE_S0_TX_SER3    0
`define ISFE_S0_ADC_KEY    1
`define ISFE_S0_CAN_WE     2
`define ISFE_S0_TB3_COL0   6
`define ISFE_S0_TB4_COL1   7
`define ISFE_S0_MASK       8'hC7

// ****************************************
// field positions, select register 1
// ****************************************
`define ISFE_S1_EXT4_SEL   6
`define ISFE_S1_EXT5_SEL   7

// ****************************************
// widths and counts
// ****************************************
`define ISFE_NVEC          11
`define ISFE_NEXT          6
`define ISFE_AW            20
`define ISFE_RESP_OKAY     2'h0
`define ISFE_RESP_SLVERR   2'h2

`endif

//--- isfe_partner.sv
// isfe_partner.sv: cpu acceptance model facing the front end
`timescale 1ns/1ns
`include "isfe_map.vh"

module isfe_partner (
	input  logic                  clk_sys,
	input  logic                  arst_n,
	input  logic                  ack_en,
	input  logic [`ISFE_NVEC-1:0] request_flag,
	input  logic                  maskable_accept,
	output logic [`ISFE_NVEC-1:0] cpu_accept
);
	// clears the lowest pending flag; level priority not modelled
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			cpu_accept <= {`ISFE_NVEC{1'h0}};
		else if (ack_en && maskable_accept && cpu_accept == 0)
			cpu_accept <= request_flag & (~request_flag + 1'h1);
		else
			cpu_accept <= {`ISFE_NVEC{1'h0}};
	end
endmodule // isfe_partner

//--- isfe_sync_edge.v
// isfe_sync_edge.v: two-stage pin synchroniser with edge detection
`timescale 1ns/1ns

module isfe_sync_edge #(
	parameter W = 1
) (
	input  wire         clk_sys,
	input  wire         arst_n,
	input  wire [W-1:0] pin_in,
	output wire [W-1:0] level,
	output wire [W-1:0] fall,
	output wire [W-1:0] rise
);

	reg [W-1:0] meta;
	reg [W-1:0] stable;
	reg [W-1:0] prev;

	genvar i;

	// ****************************************
	// per pin: meta feeds only stable
	// ****************************************
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			// idle-high pins, so reset to 1 to avoid a false rise
			always @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					meta[i]   <= 1'b1;
					stable[i] <= 1'b1;
					prev[i]   <= 1'b1;
				end else begin
					meta[i]   <= pin_in[i];
					stable[i] <= meta[i];
					prev[i]   <= stable[i];
				end
			end
			assign fall[i] = prev[i] & ~stable[i];
			assign rise[i] = ~prev[i] & stable[i];
		end
	endgenerate

	assign level = stable;

endmodule // isfe_sync_edge
